// >>> rtl/srcc_event_reg.sv
// Event status register with enable mask and summary.
// Assumes synchronous active-low reset meaning power-up.
`timescale 1ns/1ps
module srcc_event_reg import srcc_pkg::*; (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] setBits,
   input wire logic clearAll,
   input wire logic enableWrite,
   input wire logic [7:0] enableData,
   output logic [7:0] status,
   output logic [7:0] enable,
   output logic summary
);
   // Sticky events; a set in the clear cycle wins
   always_ff @(posedge clk) begin
      if (!resetn) begin
         status <= ESR_RESET;
      end else begin
         status <= ((clearAll ? 8'h00 : status) | setBits) & ESR_WMASK;
      end
   end

   // Event enable mask
   always_ff @(posedge clk) begin
      if (!resetn) begin
         enable <= ESE_RESET;
      end else if (enableWrite) begin
         enable <= enableData;
      end
   end

   assign summary = |(status & enable);
endmodule // srcc_event_reg

// >>> rtl/srcc_id_rom.sv
// Identification string memory, registered read data.
// Assumes byte index below ID_LEN; serial and versions are parameters.
`timescale 1ns/1ps
module srcc_id_rom import srcc_pkg::*; #(
   parameter logic [8*7-1:0] SERIAL = 56'h3030_3030_3030_30,
   parameter logic [8*3-1:0] MAIN_VER = 24'h312E_30,
   parameter logic [8*3-1:0] DISP_VER = 24'h312E_30
) (
   input wire logic clk,
   input wire logic [4:0] addr,
   output logic [7:0] data
);
   // ****************************************
   // Four comma-separated fields; both versions share the last one
   // ****************************************
   localparam logic [8*ID_LEN-1:0] ID_STR = {ID_MAKER, ASCII_COMMA, ID_MODEL, ASCII_COMMA,
      SERIAL, ASCII_COMMA, MAIN_VER, ASCII_SPACE, DISP_VER};

   // Registered read, first character at index 0
   always_ff @(posedge clk) begin
      data <= ID_STR[8*(ID_LEN-1-int'(addr)) +: 8];
   end
endmodule // srcc_id_rom

// >>> rtl/srcc_pkg.sv
// Constants, types and command codes of the status and common-command block.
// Assumes one 100 MHz clock and a command decoder ahead of this block.
// Functional notes
// - An 8-bit service request mask enables status byte summary bits individually.
// - Host writes the mask with a weighted integer; device loads it.
// - Mask 16 requests service only on message available bit 4.
// - Mask 48 enables requests from message available and event summary.
// - Any enabled mask bit lets enabled status bits raise the request flag.
// - Mask clears to zero at power-up and on device clear.
// - Mask query returns the mask with bit 6 reading zero.
// - Both links carry the same command set to this block.
// - Bus side implements listed interface subsets, incl. service request.
// - Clear status clears events; message available only if first in line.
// - Event enable write loads mask; out of range sets cannot-run error.
// - Event enable query returns the last written event enable mask.
// - Event status query returns the register and then clears it.
// - Identification query returns four comma-separated fields.
// - Operation complete command sets operation complete bit.
// - Operation complete query queues the ASCII character 1.
// - Reset command leaves status byte and event register unchanged.
// - Message available sets on queued response, clears after terminator sent.
// - Bit 6 is summary on status query, request flag on serial poll.
// - Event register bit layout; bits 1 and 6 always read zero.
// - Bit 6 of a written service request mask is ignored.
package srcc_pkg;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int STB_MAV_POS = 4;
   localparam int STB_ESB_POS = 5;
   localparam int STB_RQS_POS = 6;
   localparam int ESR_OPC_POS = 0;
   localparam int ESR_QYE_POS = 2;
   localparam int ESR_DDE_POS = 3;
   localparam int ESR_EXE_POS = 4;
   localparam int ESR_CME_POS = 5;
   localparam int ESR_PON_POS = 7;
   localparam logic [7:0] SRE_RESET = 8'h00;
   localparam logic [7:0] ESE_RESET = 8'h00;
   localparam logic [7:0] ESR_RESET = 8'h80;
   localparam logic [7:0] SRE_WMASK = 8'hBF;
   localparam logic [7:0] ESR_WMASK = 8'hBD;
   localparam logic [8:0] ARG_MAX = 9'h0FF;
   localparam logic [7:0] ASCII_ONE = 8'h31;
   localparam logic [7:0] ASCII_COMMA = 8'h2C;
   localparam logic [7:0] ASCII_ZERO = 8'h30;
   localparam logic [7:0] ASCII_SPACE = 8'h20;
   localparam int ID_LEN = 26;

   // Arbitrary neutral identity strings
   localparam logic [8*5-1:0] ID_MAKER = 40'h4143_4D45_43;
   localparam logic [8*4-1:0] ID_MODEL = 32'h4D30_3031;

   // ****************************************
   // Command codes from the decoder
   // ****************************************
   typedef enum logic [3:0] {
      CMD_NONE = 4'h0, CMD_CLS = 4'h1, CMD_ESE = 4'h2, CMD_ESEQ = 4'h3,
      CMD_ESRQ = 4'h4, CMD_IDNQ = 4'h5, CMD_OPC = 4'h6, CMD_OPCQ = 4'h7,
      CMD_RST = 4'h8, CMD_SRE = 4'h9, CMD_SREQ = 4'hA, CMD_STBQ = 4'hB
   } srcc_cmd_type;

   typedef struct packed {
      logic valid;
      srcc_cmd_type code;
      logic [8:0] arg;
      logic firstInLine;
   } srcc_req_type;

   typedef struct packed {
      logic queryErr;
      logic devErr;
      logic syntaxErr;
   } srcc_err_type;

endpackage

// >>> rtl/srcc_status_core.sv
// Status byte, service request and common-command execution.
// Assumes decoded commands arrive one per cycle from either link (same set).
`timescale 1ns/1ps
module srcc_status_core import srcc_pkg::*; (
   input wire logic clk,
   input wire logic resetn,
   input wire logic devClear,
   input srcc_req_type req,
   input srcc_err_type errIn,
   input wire logic serialPoll,
   input wire logic panelRequest,
   input wire logic respReady,
   input wire logic termSent,
   output logic reqReady,
   output logic [7:0] respData,
   output logic respValid,
   output logic respLast,
   output logic [7:0] pollByte,
   output logic srqOut,
   output logic deviceReset,
   output logic [7:0] serviceMask
);
   // ****************************************
   // Response sequencer states
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_BYTE = 3'b010,
      ST_ROM = 3'b100
   } srcc_state_type;

   srcc_state_type state;
   logic [7:0] service_request_mask;
   logic [7:0] esrSet;
   logic esrClear, eseWrite, esbBit, message_available_flag, service_request_flag, mssBit;
   logic [7:0] esrValue, eseValue, romData, stbValue;
   logic [4:0] romAddr;
   logic take, argOk;
   logic romWait;

   // One command set whichever link delivered it
   assign take = req.valid && reqReady;
   assign argOk = req.arg <= ARG_MAX;

   // ****************************************
   // Event register
   // ****************************************
   // Operation complete, range errors and decoder errors
   always_comb begin
      esrSet = 8'h00;
      esrSet[ESR_OPC_POS] = take && req.code == CMD_OPC;
      esrSet[ESR_EXE_POS] = take && (req.code == CMD_ESE || req.code == CMD_SRE)
         && !argOk;
      esrSet[ESR_QYE_POS] = errIn.queryErr;
      esrSet[ESR_DDE_POS] = errIn.devErr;
      esrSet[ESR_CME_POS] = errIn.syntaxErr;
   end
   assign esrClear = take && (req.code == CMD_CLS || req.code == CMD_ESRQ);
   assign eseWrite = take && req.code == CMD_ESE && argOk;

   srcc_event_reg eventReg (
      .clk(clk),
      .resetn(resetn),
      .setBits(esrSet),
      .clearAll(esrClear),
      .enableWrite(eseWrite),
      .enableData(req.arg[7:0]),
      .status(esrValue),
      .enable(eseValue),
      .summary(esbBit)
   );

   srcc_id_rom idRom (
      .clk(clk),
      .addr(romAddr),
      .data(romData)
   );

   // ****************************************
   // Service request mask
   // ****************************************
   // Reset, device clear and write; *RST leaves it alone
   always_ff @(posedge clk) begin
      if (!resetn || devClear) begin
         service_request_mask <= SRE_RESET;
      end else if (take && req.code == CMD_SRE && argOk) begin
         service_request_mask <= req.arg[7:0] & SRE_WMASK;
      end
   end
   assign serviceMask = service_request_mask;

   // ****************************************
   // Status byte
   // ****************************************
   // Message available: set on queued response, cleared after terminator
   always_ff @(posedge clk) begin
      if (!resetn) begin
         message_available_flag <= 1'b0;
      end else if (respValid && respReady) begin
         message_available_flag <= 1'b1;
      end else if (termSent || (take && req.code == CMD_CLS && req.firstInLine)) begin
         message_available_flag <= 1'b0;
      end
   end

   // Per-bit enable; mask 16 or 48 selects MESSAGE_AVAILABLE_FLAG or MESSAGE_AVAILABLE_FLAG+EVENT_SUMMARY_BIT only
   assign mssBit = |({2'b00, esbBit, message_available_flag, 4'h0} & service_request_mask);
   assign stbValue = {1'b0, mssBit, esbBit, message_available_flag, 4'h0};

   // Request flag: raised on summary, cleared by the poll, set wins
   always_ff @(posedge clk) begin
      if (!resetn) begin
         service_request_flag <= 1'b0;
      end else if (mssBit || panelRequest) begin
         service_request_flag <= 1'b1;
      end else if (serialPoll) begin
         service_request_flag <= 1'b0;
      end
   end

   // Poll byte and SRQ line, registered
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pollByte <= 8'h00;
         srqOut <= 1'b0;
      end else begin
         pollByte <= {1'b0, service_request_flag, stbValue[5:0]};
         srqOut <= service_request_flag;
      end
   end

   // Reset pulse for the rest of the meter
   always_ff @(posedge clk) begin
      if (!resetn) begin
         deviceReset <= 1'b0;
      end else begin
         deviceReset <= take && req.code == CMD_RST;
      end
   end

   // ****************************************
   // Response sequencer
   // ****************************************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= ST_IDLE;
         respValid <= 1'b0;
         respData <= 8'h00;
         respLast <= 1'b0;
         romAddr <= 5'h00;
         romWait <= 1'b0;
         reqReady <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               reqReady <= 1'b1;
               if (take) begin
                  respLast <= 1'b1;
                  unique case (req.code)
                     CMD_ESEQ: begin
                        respData <= eseValue;
                        respValid <= 1'b1;
                        reqReady <= 1'b0;
                        state <= ST_BYTE;
                     end
                     CMD_ESRQ: begin
                        respData <= esrValue;
                        respValid <= 1'b1;
                        reqReady <= 1'b0;
                        state <= ST_BYTE;
                     end
                     CMD_SREQ: begin
                        respData <= service_request_mask & SRE_WMASK;
                        respValid <= 1'b1;
                        reqReady <= 1'b0;
                        state <= ST_BYTE;
                     end
                     CMD_STBQ: begin
                        respData <= stbValue;
                        respValid <= 1'b1;
                        reqReady <= 1'b0;
                        state <= ST_BYTE;
                     end
                     CMD_OPCQ: begin
                        respData <= ASCII_ONE;
                        respValid <= 1'b1;
                        reqReady <= 1'b0;
                        state <= ST_BYTE;
                     end
                     CMD_IDNQ: begin
                        romAddr <= 5'h00;
                        romWait <= 1'b1;
                        reqReady <= 1'b0;
                        respLast <= 1'b0;
                        state <= ST_ROM;
                     end
                     default: begin
                        respValid <= 1'b0;
                     end
                  endcase
               end
            end
            ST_BYTE: begin
               if (respReady) begin
                  respValid <= 1'b0;
                  respLast <= 1'b0;
                  reqReady <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            ST_ROM: begin
               // ROM data valid one cycle after address; wait out the stale byte
               if (!respValid && romWait) begin
                  romWait <= 1'b0;
               end else if (!respValid) begin
                  respValid <= 1'b1;
                  respData <= romData;
                  respLast <= romAddr == 5'(ID_LEN - 1);
               end else if (respReady) begin
                  if (respLast) begin
                     respValid <= 1'b0;
                     respLast <= 1'b0;
                     reqReady <= 1'b1;
                     state <= ST_IDLE;
                  end else begin
                     respValid <= 1'b0;
                     romWait <= 1'b1;
                     romAddr <= romAddr + 5'h01;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   mask_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      devClear |=> service_request_mask == 8'h00)
      else $error("mask not cleared by device clear");
   mask_bit6_a: assert property (@(posedge clk) disable iff (!resetn)
      service_request_mask[STB_RQS_POS] == 1'b0)
      else $error("mask bit 6 set");
   mask_load_a: assert property (@(posedge clk) disable iff (!resetn)
      take && req.code == CMD_SRE && argOk && !devClear |=>
      service_request_mask == ($past(req.arg[7:0]) & 8'hBF))
      else $error("mask not loaded");
   mav_only_a: assert property (@(posedge clk) disable iff (!resetn)
      service_request_mask == 8'h10 |-> mssBit == message_available_flag)
      else $error("summary differs from message available");
   both_src_a: assert property (@(posedge clk) disable iff (!resetn)
      service_request_mask == 8'h30 |-> mssBit == (message_available_flag || esbBit))
      else $error("summary wrong for mask 48");
   srq_raise_a: assert property (@(posedge clk) disable iff (!resetn)
      mssBit |-> ##2 srqOut)
      else $error("SRQ not raised");
   opc_set_a: assert property (@(posedge clk) disable iff (!resetn)
      take && req.code == CMD_OPC |=> esrValue[ESR_OPC_POS])
      else $error("operation complete not set");
   opcq_one_a: assert property (@(posedge clk) disable iff (!resetn)
      take && req.code == CMD_OPCQ |=> respValid && respData == 8'h31)
      else $error("operation complete query wrong");
   esr_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      take && req.code == CMD_ESRQ && esrSet == 8'h00 |=> esrValue == 8'h00)
      else $error("event register not cleared");
   ese_range_a: assert property (@(posedge clk) disable iff (!resetn)
      take && req.code == CMD_ESE && !argOk |=> esrValue[ESR_EXE_POS]
      && $stable(eseValue))
      else $error("range error not flagged");
   esr_fixed_a: assert property (@(posedge clk) disable iff (!resetn)
      esrValue[1] == 1'b0 && esrValue[6] == 1'b0)
      else $error("reserved event bits set");
   poll_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      serialPoll && !mssBit && !panelRequest |=> !service_request_flag)
      else $error("poll did not clear request");

   srq_seen_c: cover property (@(posedge clk) disable iff (!resetn) $rose(srqOut));
   idn_done_c: cover property (@(posedge clk) disable iff (!resetn)
      state == ST_ROM && respLast && respReady);
   esr_read_c: cover property (@(posedge clk) disable iff (!resetn)
      take && req.code == CMD_ESRQ && esrValue != 8'h00);
endmodule // srcc_status_core

// >>> verification/srcc_host_model.sv
// Host controller model for the status and common-command block.
// Assumes the device core on the far side and one 100 MHz clock.
`timescale 1ns/1ps
module srcc_host_model #(
   parameter int TERM_DELAY = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic respValid,
   input wire logic [7:0] respData,
   input wire logic respLast,
   input wire logic slowMode,
   output logic respReady,
   output logic termSent
);
   // ****************************************
   // Response capture and terminator
   // ****************************************
   logic [7:0] got[$];
   int nTerm = 0;
   int delayCnt = 0;
   logic toggle = 1'b0;

   initial begin
      respReady = 1'b0;
      termSent = 1'b0;
   end

   // Keep accepted bytes, arm the terminator after the final one
   always @(posedge clk) begin
      if (respValid && respReady) begin
         got.push_back(respData);
         if (respLast) delayCnt <= TERM_DELAY;
      end else if (delayCnt > 0) begin
         delayCnt <= delayCnt - 1;
      end
      if (termSent) nTerm <= nTerm + 1;
   end

   // Handshake after the falling edge; slow mode stalls every other cycle
   always @(negedge clk) begin
      toggle <= ~toggle;
      respReady <= resetn && (!slowMode || toggle);
      termSent <= (delayCnt == 1); // One-cycle terminator pulse
   end
endmodule // srcc_host_model

// >>> verification/tb_status_reporting_common_cmds.sv
// Testbench of the status and common-command core.
// Assumes the host model drives the response side; commands come from here.
`timescale 1ns/1ps
module tb_status_reporting_common_cmds import srcc_pkg::*;;
   // ****************************************
   // Signals and instances
   // ****************************************
   logic clk = 1'b0, resetn = 1'b0, devClear = 1'b0, serialPoll = 1'b0;
   logic panelRequest = 1'b0, slowMode = 1'b0;
   srcc_req_type req = '0;
   srcc_err_type errIn = '0;
   logic respReady, termSent, reqReady, respValid, respLast, srqOut, deviceReset;
   logic [7:0] respData, pollByte, serviceMask, b;
   int n_mismatch = 0, compares = 0, nRst = 0, base = 0;

   always #5 clk = ~clk;

   srcc_status_core DUT (.clk(clk), .resetn(resetn), .devClear(devClear), .req(req),
      .errIn(errIn), .serialPoll(serialPoll), .panelRequest(panelRequest),
      .respReady(respReady), .termSent(termSent), .reqReady(reqReady),
      .respData(respData), .respValid(respValid), .respLast(respLast),
      .pollByte(pollByte), .srqOut(srqOut), .deviceReset(deviceReset),
      .serviceMask(serviceMask));

   srcc_host_model host (.clk(clk), .resetn(resetn), .respValid(respValid),
      .respData(respData), .respLast(respLast), .slowMode(slowMode),
      .respReady(respReady), .termSent(termSent));

   // Count reset pulses from the core
   always @(posedge clk) if (deviceReset === 1'b1) nRst <= nRst + 1;

   // ****************************************
   // Tasks
   // ****************************************
   task conclude;
      if (n_mismatch == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task check(string nm, logic [7:0] exp, logic [7:0] seen);
      compares++;
      if (seen !== exp) begin
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
         n_mismatch++;
      end
   endtask

   // Hold the request until taken, then drop valid
   task automatic send(srcc_cmd_type c, logic [8:0] a);
      int i;
      @(negedge clk);
      req = '{1'b1, c, a, 1'b0};
      for (i = 0; i < 50 && reqReady !== 1'b1; i++) @(negedge clk);
      if (i == 50) begin n_mismatch++; conclude(); end
      @(negedge clk);
      req.valid = 1'b0;
   endtask

   // Query, then wait for the terminator of its response
   task automatic query(srcc_cmd_type c, output logic [7:0] r);
      int i, t;
      t = host.nTerm;
      base = host.got.size();
      send(c, 9'h000);
      for (i = 0; i < 400 && host.nTerm == t; i++) @(negedge clk);
      if (i == 400) begin n_mismatch++; conclude(); end
      r = host.got[host.got.size() - 1];
   endtask

   task automatic waitSrq(logic e);
      for (int i = 0; i < 12 && srqOut !== e; i++) @(negedge clk);
      check("srqOut", {7'h00, e}, {7'h00, srqOut});
   endtask

   task automatic poll;
      @(negedge clk) serialPoll = 1'b1;
      @(negedge clk) serialPoll = 1'b0;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      int nc, n;
      repeat (5) @(posedge clk);
      @(negedge clk) resetn = 1'b1;
      @(negedge clk);
      check("serviceMask", 8'h00, serviceMask);
      query(CMD_ESRQ, b); check("esr", 8'h80, b);
      query(CMD_ESRQ, b); check("esr", 8'h00, b);
      send(CMD_SRE, 9'h0FF); check("serviceMask", 8'hBF, serviceMask);
      query(CMD_SREQ, b); check("sre", 8'hBF, b);
      send(CMD_SRE, 9'h100); check("serviceMask", 8'hBF, serviceMask);
      send(CMD_ESE, 9'h020);
      send(CMD_ESE, 9'h1FF);
      query(CMD_ESEQ, b); check("ese", 8'h20, b);
      query(CMD_ESRQ, b); check("esr", 8'h10, b);
      @(negedge clk) devClear = 1'b1;
      @(negedge clk) devClear = 1'b0;
      check("serviceMask", 8'h00, serviceMask);
      poll();
      // Enabled event but mask only on message available
      send(CMD_SRE, 9'h010);
      @(negedge clk) errIn.syntaxErr = 1'b1;
      @(negedge clk) errIn.syntaxErr = 1'b0;
      repeat (6) @(negedge clk);
      check("srqOut", 8'h00, {7'h00, srqOut});
      query(CMD_STBQ, b); check("stb", 8'h20, b);
      send(CMD_SRE, 9'h030); waitSrq(1'b1);
      check("pollByte", 8'h40, pollByte & 8'h40);
      query(CMD_STBQ, b); check("stb", 8'h60, b);
      send(CMD_CLS, 9'h000);
      query(CMD_ESRQ, b); check("esr", 8'h00, b);
      poll(); waitSrq(1'b0);
      // Request from a pending response, held after the terminator until the poll
      send(CMD_SRE, 9'h010);
      query(CMD_OPCQ, b); check("opcq", ASCII_ONE, b);
      check("srqOut", 8'h01, {7'h00, srqOut});
      poll(); waitSrq(1'b0);
      @(negedge clk) panelRequest = 1'b1;
      @(negedge clk) panelRequest = 1'b0;
      waitSrq(1'b1);
      poll(); waitSrq(1'b0);
      send(CMD_OPC, 9'h000);
      query(CMD_ESRQ, b); check("esr", 8'h01, b);
      @(negedge clk) errIn = '{1'b1, 1'b1, 1'b0};
      @(negedge clk) errIn = '0;
      n = nRst;
      send(CMD_RST, 9'h000);
      repeat (3) @(negedge clk);
      check("deviceReset", 8'h01, 8'(nRst - n));
      query(CMD_ESRQ, b); check("esr", 8'h0C, b);
      // Identification with a stalling host
      slowMode = 1'b1;
      query(CMD_IDNQ, b);
      check("idnLen", 8'h1A, 8'(host.got.size() - base));
      nc = 0;
      for (int k = base; k < host.got.size(); k++) if (host.got[k] === ASCII_COMMA) nc++;
      check("idnCommas", 8'h03, 8'(nc));
      for (int k = 0; k < 5; k++) check("idnMaker", ID_MAKER[39-8*k -: 8], host.got[base+k]);
      conclude();
   end
endmodule // tb_status_reporting_common_cmds
